// >>> rtl/bitalu_pkg.sv
package bitalu_pkg;

  localparam int unsigned WORD_W         = 32;
  localparam int unsigned DWORD_W        = 64;
  localparam int unsigned ROT_W          = 5;
  localparam int unsigned FIELD_W        = 6;
  localparam int unsigned LATENCY_CYCLES = 1;

  // Flag vector layout
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_V = 0;

  localparam logic [3:0]  FLAGS_RESET  = 4'h0;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_BYTE_SWAP_WORD         = 4'h0,
    OP_HALFWORD_BYTE_SWAP     = 4'h1,
    OP_LOW_HALF_SWAP_SIGN_EXT = 4'h2,
    OP_BIT_ORDER_FLIP         = 4'h3,
    OP_CARRY_ROTATE_ONE       = 4'h4,
    OP_ROTATE_RIGHT           = 4'h5,
    OP_SIGNED_MUL_ACC_LONG    = 4'h6,
    OP_SIGNED_MUL_LONG        = 4'h7,
    OP_UNSIGNED_MUL_ACC_LONG  = 4'h8,
    OP_UNSIGNED_MUL_LONG      = 4'h9,
    OP_SIGNED_FIELD_EXTRACT   = 4'ha,
    OP_UNSIGNED_FIELD_EXTRACT = 4'hb,
    OP_SIGN_EXT_BYTE          = 4'hc,
    OP_SIGN_EXT_HALF          = 4'hd,
    OP_ZERO_EXT_BYTE          = 4'he,
    OP_ZERO_EXT_HALF          = 4'hf
  } alu_op_e;

endpackage

// >>> rtl/bit_field_extract.sv
`timescale 1ns/1ps
`default_nettype none

module bit_field_extract #(
  parameter int unsigned DATA_W = bitalu_pkg::WORD_W,
  parameter int unsigned POS_W  = bitalu_pkg::ROT_W,
  parameter int unsigned LEN_W  = bitalu_pkg::FIELD_W
) (
  input  wire logic [DATA_W-1:0] src_i,
  input  wire logic [POS_W-1:0]  lsb_i,
  input  wire logic [LEN_W-1:0]  width_i,
  input  wire logic              signed_i,
  output logic      [DATA_W-1:0] field_o
);

  logic [DATA_W-1:0] shifted;
  logic [DATA_W-1:0] mask;
  logic [POS_W-1:0]  top_sel;
  logic              fill;

  // Bits above the source top read as zero when lsb plus width runs past it
  assign shifted = src_i >> lsb_i;
  assign mask    = ~({DATA_W{1'b1}} << width_i);
  assign top_sel = (width_i == '0) ? '0 : POS_W'(width_i - 1'b1);
  assign fill    = signed_i & (width_i != '0) & shifted[top_sel];
  assign field_o = (shifted & mask) | ({DATA_W{fill}} & ~mask);

endmodule

`default_nettype wire

// >>> rtl/bit_manip_multiply_alu.sv
`timescale 1ns/1ps
`default_nettype none

module bit_manip_multiply_alu (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            ce_i,
  input  wire logic                            valid_i,
  input  wire bitalu_pkg::alu_op_e             op_i,
  input  wire logic [bitalu_pkg::WORD_W-1:0]   src_a_i,
  input  wire logic [bitalu_pkg::WORD_W-1:0]   src_b_i,
  input  wire logic [bitalu_pkg::WORD_W-1:0]   acc_lo_i,
  input  wire logic [bitalu_pkg::WORD_W-1:0]   acc_hi_i,
  input  wire logic [bitalu_pkg::ROT_W-1:0]    rot_amt_i,
  input  wire logic [bitalu_pkg::ROT_W-1:0]    lsb_i,
  input  wire logic [bitalu_pkg::FIELD_W-1:0]  width_i,
  input  wire logic                            set_flags_i,
  input  wire logic [3:0]                      flags_i,
  output logic                                 valid_o,
  output logic      [bitalu_pkg::WORD_W-1:0]   result_lo_o,
  output logic      [bitalu_pkg::WORD_W-1:0]   result_hi_o,
  output logic                                 hi_write_o,
  output logic      [3:0]                      flags_o
);

  localparam int unsigned W  = bitalu_pkg::WORD_W;
  localparam int unsigned DW = bitalu_pkg::DWORD_W;
  localparam int unsigned FC = bitalu_pkg::FLAG_C;
  localparam int unsigned FV = bitalu_pkg::FLAG_V;
  localparam int unsigned FN = bitalu_pkg::FLAG_N;
  localparam int unsigned FZ = bitalu_pkg::FLAG_Z;

  logic                 fire;
  logic [W-1:0]         a;
  logic [W-1:0]         byte_swap_word;
  logic [W-1:0]         halfword_byte_swap;
  logic [W-1:0]         low_half_swap_sign_ext;
  logic [W-1:0]         bit_order_flip;
  logic [W-1:0]         carry_rotate_one;
  logic [DW-1:0]        rot_wide;
  logic [W-1:0]         rot_val;
  logic                 rot_carry;
  logic [W-1:0]         sign_ext_byte;
  logic [W-1:0]         sign_ext_half;
  logic [W-1:0]         zero_ext_byte;
  logic [W-1:0]         zero_ext_half;
  logic signed [DW-1:0] prod_signed;
  logic [DW-1:0]        prod_unsigned;
  logic [DW-1:0]        acc_pair;
  logic [DW-1:0]        sum_signed;
  logic [DW-1:0]        sum_unsigned;
  logic [W-1:0]         field_val;
  logic                 field_is_signed;
  logic                 is_rotate_kind;
  logic                 flag_form;
  logic [W-1:0]         res_lo_nxt;
  logic [W-1:0]         res_hi_nxt;
  logic                 hi_wr_nxt;
  logic                 carry_nxt;
  logic [3:0]           flags_nxt;

  logic                 valid_r;
  logic [W-1:0]         res_lo_r;
  logic [W-1:0]         res_hi_r;
  logic                 hi_wr_r;
  logic [3:0]           flags_r;

  assign fire = valid_i & ce_i;
  assign a    = src_a_i;

  // Byte and bit reordering
  assign byte_swap_word         = {a[7:0], a[15:8], a[23:16], a[31:24]};
  assign halfword_byte_swap     = {a[23:16], a[31:24], a[7:0], a[15:8]};
  assign low_half_swap_sign_ext = {{16{a[7]}}, a[7:0], a[15:8]};
  assign bit_order_flip         = {<<{a}};

  // Carry rotate: incoming carry enters at the top, bit 0 leaves as carry
  assign carry_rotate_one = {flags_i[FC], a[W-1:1]};

  // Rotate right; last bit rotated out lands in result bit 31
  assign rot_wide  = {a, a} >> rot_amt_i;
  assign rot_val   = rot_wide[W-1:0];
  assign rot_carry = rot_val[W-1];

  // Extension works on the rotated source; zero rotation passes it straight
  assign sign_ext_byte = {{24{rot_val[7]}}, rot_val[7:0]};
  assign sign_ext_half = {{16{rot_val[15]}}, rot_val[15:0]};
  assign zero_ext_byte = {24'h00_0000, rot_val[7:0]};
  assign zero_ext_half = {16'h0000, rot_val[15:0]};

  // Long multiply, accumulate wraps modulo 2^64
  assign prod_signed   = $signed(src_a_i) * $signed(src_b_i);
  assign prod_unsigned = {32'h0000_0000, src_a_i} * {32'h0000_0000, src_b_i};
  assign acc_pair      = {acc_hi_i, acc_lo_i};
  assign sum_signed    = DW'(prod_signed) + acc_pair;
  assign sum_unsigned  = prod_unsigned + acc_pair;

  assign field_is_signed = (op_i == bitalu_pkg::OP_SIGNED_FIELD_EXTRACT);

  bit_field_extract #(
    .DATA_W (W),
    .POS_W  (bitalu_pkg::ROT_W),
    .LEN_W  (bitalu_pkg::FIELD_W)
  ) u_field (
    .src_i    (src_a_i),
    .lsb_i    (lsb_i),
    .width_i  (width_i),
    .signed_i (field_is_signed),
    .field_o  (field_val)
  );

  assign is_rotate_kind = (op_i == bitalu_pkg::OP_CARRY_ROTATE_ONE) |
                          (op_i == bitalu_pkg::OP_ROTATE_RIGHT);
  assign flag_form      = set_flags_i & is_rotate_kind;

  always_comb begin
    res_lo_nxt = '0;
    res_hi_nxt = res_hi_r;
    hi_wr_nxt  = 1'b0;
    unique case (op_i)
      bitalu_pkg::OP_BYTE_SWAP_WORD: begin
        res_lo_nxt = byte_swap_word;
      end
      bitalu_pkg::OP_HALFWORD_BYTE_SWAP: begin
        res_lo_nxt = halfword_byte_swap;
      end
      bitalu_pkg::OP_LOW_HALF_SWAP_SIGN_EXT: begin
        res_lo_nxt = low_half_swap_sign_ext;
      end
      bitalu_pkg::OP_BIT_ORDER_FLIP: begin
        res_lo_nxt = bit_order_flip;
      end
      bitalu_pkg::OP_CARRY_ROTATE_ONE: res_lo_nxt = carry_rotate_one;
      bitalu_pkg::OP_ROTATE_RIGHT:     res_lo_nxt = rot_val;
      bitalu_pkg::OP_SIGNED_MUL_ACC_LONG: begin
        res_lo_nxt = sum_signed[W-1:0];
        res_hi_nxt = sum_signed[DW-1:W];
        hi_wr_nxt  = 1'b1;
      end
      bitalu_pkg::OP_SIGNED_MUL_LONG: begin
        res_lo_nxt = prod_signed[W-1:0];
        res_hi_nxt = prod_signed[DW-1:W];
        hi_wr_nxt  = 1'b1;
      end
      bitalu_pkg::OP_UNSIGNED_MUL_ACC_LONG: begin
        res_lo_nxt = sum_unsigned[W-1:0];
        res_hi_nxt = sum_unsigned[DW-1:W];
        hi_wr_nxt  = 1'b1;
      end
      bitalu_pkg::OP_UNSIGNED_MUL_LONG: begin
        res_lo_nxt = prod_unsigned[W-1:0];
        res_hi_nxt = prod_unsigned[DW-1:W];
        hi_wr_nxt  = 1'b1;
      end
      bitalu_pkg::OP_SIGNED_FIELD_EXTRACT,
      bitalu_pkg::OP_UNSIGNED_FIELD_EXTRACT: begin
        res_lo_nxt = field_val;
      end
      bitalu_pkg::OP_SIGN_EXT_BYTE: res_lo_nxt = sign_ext_byte;
      bitalu_pkg::OP_SIGN_EXT_HALF: res_lo_nxt = sign_ext_half;
      bitalu_pkg::OP_ZERO_EXT_BYTE: res_lo_nxt = zero_ext_byte;
      bitalu_pkg::OP_ZERO_EXT_HALF: res_lo_nxt = zero_ext_half;
    endcase
  end

  // A zero-length rotate keeps carry; carry rotate always shifts out bit 0
  assign carry_nxt = (op_i == bitalu_pkg::OP_CARRY_ROTATE_ONE) ? a[0] :
                     (rot_amt_i == '0) ? flags_i[FC] : rot_carry;

  // Only the rotate flag forms touch N, Z, C; V always passes through
  assign flags_nxt = flag_form ?
                     {res_lo_nxt[W-1], (res_lo_nxt == '0), carry_nxt, flags_i[FV]} :
                     flags_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
    end else if (ce_i) begin
      valid_r <= valid_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_lo_r <= bitalu_pkg::RESULT_RESET;
      res_hi_r <= bitalu_pkg::RESULT_RESET;
      hi_wr_r  <= 1'b0;
      flags_r  <= bitalu_pkg::FLAGS_RESET;
    end else if (fire) begin
      res_lo_r <= res_lo_nxt;
      res_hi_r <= res_hi_nxt;
      hi_wr_r  <= hi_wr_nxt;
      flags_r  <= flags_nxt;
    end
  end

  assign valid_o     = valid_r;
  assign result_lo_o = res_lo_r;
  assign result_hi_o = res_hi_r;
  assign hi_write_o  = hi_wr_r;
  assign flags_o     = flags_r;

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  swap_word_a: assert property (
    fire && op_i == bitalu_pkg::OP_BYTE_SWAP_WORD |=>
      valid_o && result_lo_o == {$past(src_a_i[7:0]), $past(src_a_i[15:8]),
        $past(src_a_i[23:16]), $past(src_a_i[31:24])} && flags_o == $past(flags_i))
    else $error("byte swap word result wrong");

  half_swap_a: assert property (
    fire && op_i == bitalu_pkg::OP_HALFWORD_BYTE_SWAP |=>
      result_lo_o[15:0] == {$past(src_a_i[7:0]), $past(src_a_i[15:8])} &&
      result_lo_o[31:16] == {$past(src_a_i[23:16]), $past(src_a_i[31:24])})
    else $error("halfword byte swap result wrong");

  low_swap_sext_a: assert property (
    fire && op_i == bitalu_pkg::OP_LOW_HALF_SWAP_SIGN_EXT |=>
      $signed(result_lo_o) == $signed({$past(src_a_i[7:0]), $past(src_a_i[15:8])}))
    else $error("low half swap sign extend wrong");

  rotate_keeps_v_a: assert property (
    fire && flag_form |=>
      flags_o[FV] == $past(flags_i[FV]) &&
      flags_o[FN] == result_lo_o[W-1] && flags_o[FZ] == (result_lo_o == '0))
    else $error("rotate flag form updated wrong flags");

  smac_long_a: assert property (
    fire && op_i == bitalu_pkg::OP_SIGNED_MUL_ACC_LONG |=>
      hi_write_o && $signed({result_hi_o, result_lo_o}) ==
        $signed($past(src_a_i)) * $signed($past(src_b_i)) +
        $signed({$past(acc_hi_i), $past(acc_lo_i)}))
    else $error("signed multiply accumulate long wrong");

  smul_long_a: assert property (
    fire && op_i == bitalu_pkg::OP_SIGNED_MUL_LONG |=>
      hi_write_o && $signed({result_hi_o, result_lo_o}) ==
        $signed($past(src_a_i)) * $signed($past(src_b_i)) &&
      flags_o == $past(flags_i))
    else $error("signed multiply long wrong");

  umac_long_a: assert property (
    fire && op_i == bitalu_pkg::OP_UNSIGNED_MUL_ACC_LONG |=>
      {result_hi_o, result_lo_o} == DW'($past(src_a_i)) * DW'($past(src_b_i)) +
        {$past(acc_hi_i), $past(acc_lo_i)})
    else $error("unsigned multiply accumulate long wrong");

  umul_long_a: assert property (
    fire && op_i == bitalu_pkg::OP_UNSIGNED_MUL_LONG |=>
      hi_write_o && {result_hi_o, result_lo_o} ==
        DW'($past(src_a_i)) * DW'($past(src_b_i)))
    else $error("unsigned multiply long wrong");

  sfield_sign_a: assert property (
    fire && op_i == bitalu_pkg::OP_SIGNED_FIELD_EXTRACT && width_i != '0 &&
      (32'(lsb_i) + 32'(width_i)) <= 32'(W) |=>
      $signed(result_lo_o) == ($signed($past(src_a_i) << (7'(W) - 7'($past(lsb_i)) -
        7'($past(width_i)))) >>> (7'(W) - 7'($past(width_i)))))
    else $error("signed field extract wrong");

  ufield_zero_a: assert property (
    fire && op_i == bitalu_pkg::OP_UNSIGNED_FIELD_EXTRACT && width_i != '0 &&
      width_i < 6'd32 |=>
      (result_lo_o >> $past(width_i)) == '0)
    else $error("unsigned field extract upper bits not zero");

  sext_half_a: assert property (
    fire && op_i == bitalu_pkg::OP_SIGN_EXT_HALF && rot_amt_i == 5'h10 |=>
      result_lo_o == {{16{$past(src_a_i[31])}}, $past(src_a_i[31:16])})
    else $error("sign extend halfword after rotate wrong");

  zext_byte_a: assert property (
    fire && op_i == bitalu_pkg::OP_ZERO_EXT_BYTE && rot_amt_i == 5'h08 |=>
      result_lo_o == {24'h00_0000, $past(src_a_i[15:8])} && flags_o == $past(flags_i))
    else $error("zero extend byte after rotate wrong");

  carry_into_top_a: assert property (
    fire && op_i == bitalu_pkg::OP_CARRY_ROTATE_ONE |=>
      result_lo_o[W-1] == $past(flags_i[FC]) &&
      result_lo_o[W-2:0] == $past(src_a_i[W-1:1]))
    else $error("carry rotate result wrong");

  ror_carry_out_a: assert property (
    fire && flag_form && op_i == bitalu_pkg::OP_ROTATE_RIGHT && rot_amt_i != '0 |=>
      flags_o[FC] == $past(src_a_i[rot_amt_i - 5'h01]))
    else $error("rotate carry not last bit rotated out");

  logic [W-1:0] flip_back;
  assign flip_back = {<<{result_lo_o}};
  bit_flip_a: assert property (
    fire && op_i == bitalu_pkg::OP_BIT_ORDER_FLIP |=>
      result_lo_o[0] == $past(src_a_i[W-1]) && result_lo_o[W-1] == $past(src_a_i[0]) &&
      flip_back == $past(src_a_i))
    else $error("bit order flip wrong");

  flags_pass_a: assert property (
    fire && !flag_form |=> flags_o == $past(flags_i))
    else $error("flags changed by a flagless operation");

  cover_mac_back_to_back: cover property (
    fire && op_i == bitalu_pkg::OP_SIGNED_MUL_ACC_LONG ##1
    fire && op_i == bitalu_pkg::OP_UNSIGNED_MUL_ACC_LONG);

  cover_rotate_flags: cover property (
    fire && flag_form && op_i == bitalu_pkg::OP_ROTATE_RIGHT ##1 flags_o[FZ]);

  cover_stall_then_fire: cover property (
    valid_i && !ce_i ##1 fire && op_i == bitalu_pkg::OP_SIGNED_FIELD_EXTRACT);

  cover_carry_rotate: cover property (
    fire && op_i == bitalu_pkg::OP_CARRY_ROTATE_ONE && set_flags_i && flags_i[FC]);

endmodule

`default_nettype wire

// >>> sim/decode_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none

module decode_regfile_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic [3:0] load_flags_i,
  input  wire logic       wb_valid_i,
  input  wire logic [3:0] wb_flags_i,
  output logic      [3:0] flags_o
);
  logic [3:0] flags_r;

  // Flags written back by each completed operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_r <= 4'h0;
    end else if (wb_valid_i) begin
      flags_r <= wb_flags_i;
    end
  end

  // Decode may force a flag set ahead of the written-back one
  assign flags_o = load_i ? load_flags_i : flags_r;
endmodule

`default_nettype wire

// >>> sim/test_bit_manip_multiply_alu.sv
`timescale 1ns/1ps
`default_nettype none

module test_bit_manip_multiply_alu;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic valid_i = 1'b0;
  bitalu_pkg::alu_op_e op_i = bitalu_pkg::OP_BYTE_SWAP_WORD;
  logic [31:0] src_a_i = 32'h0;
  logic [31:0] src_b_i = 32'h0;
  logic [31:0] acc_lo_i = 32'h0;
  logic [31:0] acc_hi_i = 32'h0;
  logic [4:0]  sel = 5'h0;
  logic        set_flags_i = 1'b0;
  logic        load_i = 1'b0;
  logic [3:0]  load_flags_i = 4'h0;
  logic [3:0]  flags_i;
  logic        valid_o;
  logic        hi_write_o;
  logic [31:0] result_lo_o;
  logic [31:0] result_hi_o;
  logic [3:0]  flags_o;
  logic [3:0]  shadow_fl = 4'h0;
  logic [31:0] shadow_hi = 32'h0;
  logic        use_fb = 1'b0;
  int          err_total = 0;
  int          n_tests = 0;
  logic [31:0] fa [6] = '{32'hf0f0_1234, 32'h8000_0000, 32'hdead_beef, 32'h0000_0f00,
                          32'h1234_5678, 32'hffff_ffff};
  logic [4:0]  fp [6] = '{5'h04, 5'h1f, 5'h00, 5'h08, 5'h1c, 5'h05};
  logic [5:0]  fw [6] = '{6'h08, 6'h01, 6'h20, 6'h04, 6'h08, 6'h00};

  always #20 clk_i = ~clk_i;

  bit_manip_multiply_alu i_bit_manip_multiply_alu (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .valid_i(valid_i), .op_i(op_i),
    .src_a_i(src_a_i), .src_b_i(src_b_i), .acc_lo_i(acc_lo_i), .acc_hi_i(acc_hi_i),
    .rot_amt_i(sel), .lsb_i(sel), .width_i(src_b_i[5:0]), .set_flags_i(set_flags_i),
    .flags_i(flags_i), .valid_o(valid_o), .result_lo_o(result_lo_o),
    .result_hi_o(result_hi_o), .hi_write_o(hi_write_o), .flags_o(flags_o));

  decode_regfile_model i_decode_regfile_model (
    .clk_i(clk_i), .rst_i(rst_i), .load_i(load_i), .load_flags_i(load_flags_i),
    .wb_valid_i(valid_o), .wb_flags_i(flags_o), .flags_o(flags_i));

  // Returns {hi_write, high word, low word, flags}
  function automatic logic [68:0] ref_calc(input logic [3:0] op, input logic [31:0] a, b,
                                           input logic [4:0] n, input logic sf,
                                           input logic [3:0] fl, input logic [31:0] ph);
    logic [31:0] r;
    logic [31:0] x;
    logic [63:0] p;
    logic [63:0] m;
    logic [63:0] s;
    logic [3:0]  f;
    r = 32'h0;
    f = fl;
    p = 64'h0;
    x = 32'({a, a} >> n);
    s = {32'h0, a} >> n;
    m = (64'h1 << b[5:0]) - 64'h1;
    case (op)
      4'h0: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      4'h1: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      4'h2: r = {{16{a[7]}}, a[7:0], a[15:8]};
      4'h3: for (int i = 0; i < 32; i++) r[i] = a[31-i];
      4'h4: r = {fl[1], a[31:1]};
      4'h5: r = x;
      4'h6, 4'h7: p = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      4'h8, 4'h9: p = {32'h0, a} * {32'h0, b};
      4'ha, 4'hb: begin
        r = 32'(s & m);
        if (op == 4'ha && b[5:0] != 6'h0 && s[b[5:0]-6'h1]) r = r | ~32'(m);
      end
      4'hc: r = {{24{x[7]}}, x[7:0]};
      4'hd: r = {{16{x[15]}}, x[15:0]};
      4'he: r = {24'h0, x[7:0]};
      default: r = {16'h0, x[15:0]};
    endcase
    if (op == 4'h6 || op == 4'h8) p = p + {acc_hi_i, acc_lo_i};
    if (sf && op == 4'h4) f[1] = a[0];
    if (sf && op == 4'h5 && n != 5'h0) f[1] = a[n-5'h1];
    if (sf && (op == 4'h4 || op == 4'h5)) begin
      f[3] = r[31];
      f[2] = (r == 32'h0);
    end
    return (op >= 4'h6 && op <= 4'h9) ? {1'b1, p, f} : {1'b0, ph, r, f};
  endfunction

  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_op(input bitalu_pkg::alu_op_e op, input logic [31:0] a, b,
                       input logic [4:0] n, input logic sf, input logic [3:0] fl);
    logic [68:0] e;
    e = ref_calc(4'(op), a, b, n, sf, use_fb ? shadow_fl : fl, shadow_hi);
    @(negedge clk_i);
    op_i = op;
    src_a_i = a;
    src_b_i = b;
    sel = n;
    set_flags_i = sf;
    load_i = ~use_fb;
    load_flags_i = fl;
    valid_i = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    valid_i = 1'b0;
    load_i = 1'b0;
    check({valid_o, hi_write_o, result_hi_o, result_lo_o, flags_o}, {1'b1, e});
    shadow_fl = e[3:0];
    shadow_hi = e[67:36];
  endtask

  task automatic sc_swaps;
    do_op(bitalu_pkg::OP_BYTE_SWAP_WORD, 32'h1234_5678, 32'h0, 5'h0, 1'b1, 4'ha);
    do_op(bitalu_pkg::OP_HALFWORD_BYTE_SWAP, 32'h1234_5678, 32'h0, 5'h0, 1'b0, 4'h5);
    do_op(bitalu_pkg::OP_LOW_HALF_SWAP_SIGN_EXT, 32'h1234_80ff, 32'h0, 5'h0, 1'b0, 4'hf);
    do_op(bitalu_pkg::OP_LOW_HALF_SWAP_SIGN_EXT, 32'hffff_7f01, 32'h0, 5'h0, 1'b1, 4'h0);
    do_op(bitalu_pkg::OP_BIT_ORDER_FLIP, 32'h8000_0003, 32'h0, 5'h0, 1'b1, 4'h9);
  endtask

  task automatic sc_rotate;
    do_op(bitalu_pkg::OP_ROTATE_RIGHT, 32'h0000_0004, 32'h0, 5'h03, 1'b1, 4'h1);
    do_op(bitalu_pkg::OP_ROTATE_RIGHT, 32'h0000_0008, 32'h0, 5'h03, 1'b1, 4'h2);
    do_op(bitalu_pkg::OP_ROTATE_RIGHT, 32'h0000_0000, 32'h0, 5'h00, 1'b1, 4'h2);
    do_op(bitalu_pkg::OP_ROTATE_RIGHT, 32'h0000_0001, 32'h0, 5'h1f, 1'b0, 4'h5);
    do_op(bitalu_pkg::OP_CARRY_ROTATE_ONE, 32'h0000_0001, 32'h0, 5'h0, 1'b1, 4'h0);
    do_op(bitalu_pkg::OP_CARRY_ROTATE_ONE, 32'h0000_0002, 32'h0, 5'h0, 1'b1, 4'h3);
    do_op(bitalu_pkg::OP_CARRY_ROTATE_ONE, 32'hffff_fffe, 32'h0, 5'h0, 1'b0, 4'h2);
    use_fb = 1'b1;
    do_op(bitalu_pkg::OP_CARRY_ROTATE_ONE, 32'h0000_0004, 32'h0, 5'h0, 1'b1, 4'h0);
    use_fb = 1'b0;
  endtask

  task automatic sc_mul;
    acc_lo_i = 32'hffff_fff0;
    acc_hi_i = 32'hffff_ffff;
    for (int i = 0; i < 4; i++) begin
      do_op(bitalu_pkg::alu_op_e'(4'(6 + i)), 32'hffff_fffe, 32'h3, 5'h0, 1'b1, 4'h9);
      do_op(bitalu_pkg::alu_op_e'(4'(6 + i)), 32'h8000_0000, 32'h8000_0001, 5'h0, 1'b0,
            4'h6);
    end
  endtask

  task automatic sc_field;
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 6; j++) begin
        do_op(bitalu_pkg::alu_op_e'(4'(10 + k)), fa[j], {26'h0, fw[j]}, fp[j], 1'b0,
              4'h3);
      end
    end
  endtask

  task automatic sc_ext;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        do_op(bitalu_pkg::alu_op_e'(4'(12 + k)), 32'h80ff_7f01, 32'h0, 5'(8 * j), 1'b1,
              4'h6);
      end
    end
  endtask

  task automatic sc_pipe;
    logic [68:0] ea;
    logic [68:0] eb;
    ea = ref_calc(4'h0, 32'h1122_3344, 32'h0, 5'h0, 1'b0, 4'h4, shadow_hi);
    eb = ref_calc(4'h9, 32'h0001_0000, 32'h0001_0000, 5'h0, 1'b0, 4'h8, 32'h0);
    @(negedge clk_i);
    valid_i = 1'b1;
    load_i = 1'b1;
    load_flags_i = 4'h4;
    op_i = bitalu_pkg::OP_BYTE_SWAP_WORD;
    src_a_i = 32'h1122_3344;
    set_flags_i = 1'b0;
    @(negedge clk_i);
    check({valid_o, hi_write_o, result_hi_o, result_lo_o, flags_o}, {1'b1, ea});
    op_i = bitalu_pkg::OP_UNSIGNED_MUL_LONG;
    src_a_i = 32'h0001_0000;
    src_b_i = 32'h0001_0000;
    load_flags_i = 4'h8;
    @(negedge clk_i);
    check({valid_o, hi_write_o, result_hi_o, result_lo_o, flags_o}, {1'b1, eb});
    ce_i = 1'b0;
    op_i = bitalu_pkg::OP_BIT_ORDER_FLIP;
    repeat (2) @(negedge clk_i);
    check({valid_o, hi_write_o, result_hi_o, result_lo_o, flags_o}, {1'b1, eb});
    ce_i = 1'b1;
    valid_i = 1'b0;
    load_i = 1'b0;
    @(negedge clk_i);
    check({valid_o, hi_write_o, result_hi_o, result_lo_o, flags_o}, {1'b0, eb});
    // Mid-run reset while frozen clears results and the written-back flags
    ce_i = 1'b0;
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    ce_i = 1'b1;
    shadow_fl = 4'h0;
    shadow_hi = 32'h0;
    use_fb = 1'b1;
    do_op(bitalu_pkg::OP_HALFWORD_BYTE_SWAP, 32'habcd_0102, 32'h0, 5'h0, 1'b0, 4'hf);
    use_fb = 1'b0;
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    sc_swaps();
    sc_rotate();
    sc_mul();
    sc_field();
    sc_ext();
    sc_pipe();
    final_report();
  end
endmodule

`default_nettype wire
